// ==== core/rbuf_top.sv ====
/*
 * 14-bit registered buffer: captures the data pins at each crossing of the
 * clock pair (true rising, complement falling) that finds the capture stage empty or the buffer not full, and holds them on q.
 * Assumes all pins arrive asynchronously to clk and are much slower than it;
 * the receiver of q may stall through q_ready.
 */
`timescale 1ns/10ps
`default_nettype none
module rbuf_top
    import rbuf_pkg::*;
(
    input wire logic clk, // System clock, 125 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic rst_pin_n, // Device reset pin, active low
    input wire logic ck_t_pin, // True clock pin
    input wire logic ck_c_pin, // Complement clock pin
    input wire logic [rbuf_pkg::DATA_W-1:0] d_pin, // Data pins
    output logic [rbuf_pkg::DATA_W-1:0] q, // Registered outputs
    output logic q_update, // Pulse when q takes a new word
    input wire logic q_ready, // Receiver accepts a new word
    output logic rcv_enable, // Input receivers powered
    output logic cap_overrun // Pulse: crossing found buffer and capture stage both full
);
    import rbuf_pkg::*;

    logic [2:0] rst_sync_ff;
    logic rst_stable_n_ff;
    logic standby;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_ff;
    logic [PIN_W-1:0] pin_s2_ff;
    logic [PIN_W-1:0] pin_s3_ff;
    logic [PIN_W-1:0] pin_stable_ff;
    logic [PIN_W-1:0] nxt_pin_stable;
    logic cross_state;
    logic cross_prev_ff;
    logic cross_hit;
    logic cap_valid_ff;
    rbuf_word_t cap_data_ff;
    logic cap_ready;
    logic buf_valid;
    rbuf_word_t buf_data;
    logic buf_pop;
    rbuf_word_t q_ff;
    logic q_update_ff;
    logic overrun_ff;

    // Reset pin through three flops; a change counts once stages 2 and 3 agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_sync_ff <= 3'h0;
            rst_stable_n_ff <= 1'b0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[1:0], rst_pin_n};
            if (rst_sync_ff[1] == rst_sync_ff[2]) begin
                rst_stable_n_ff <= rst_sync_ff[2];
            end
        end
    end

    assign standby = sys_rst || !rst_stable_n_ff;
    assign rcv_enable = !standby;

    // disabled receivers feed constants, pins are never looked at
    assign pin_raw = rcv_enable ? {ck_c_pin, ck_t_pin, d_pin} : '0;

    always_ff @(posedge clk) begin
        if (standby) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
        end else begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // each pin filtered on its own
    always_comb begin
        nxt_pin_stable = pin_stable_ff;
        for (int i = 0; i < PIN_W; i++) begin
            if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                nxt_pin_stable[i] = pin_s3_ff[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (standby) begin
            pin_stable_ff <= '0;
        end else begin
            pin_stable_ff <= nxt_pin_stable;
        end
    end

    // crossing is true high with complement low, newly reached
    assign cross_state = pin_stable_ff[PIN_CK_T] && !pin_stable_ff[PIN_CK_C];
    assign cross_hit = cross_state && !cross_prev_ff;

    always_ff @(posedge clk) begin
        if (standby) begin
            // Standby presets mid-crossing, lost at the first edge after release since pin_stable_ff is cleared; pins held crossed still fake an edge
            cross_prev_ff <= 1'b1;
        end else begin
            cross_prev_ff <= cross_state;
        end
    end

    // capture data pins on the crossing
    always_ff @(posedge clk) begin
        if (standby) begin
            cap_valid_ff <= 1'b0;
            cap_data_ff <= Q_RESET;
        end else if (cross_hit && (!cap_valid_ff || cap_ready)) begin
            // A held word is never overwritten; the new crossing is the one dropped
            cap_valid_ff <= 1'b1;
            cap_data_ff <= pin_stable_ff[DATA_W-1:0];
        end else if (cap_ready) begin
            cap_valid_ff <= 1'b0;
        end
    end

    // Crossing lost because the buffer and the capture stage were both full
    always_ff @(posedge clk) begin
        if (standby) begin
            overrun_ff <= 1'b0;
        end else begin
            overrun_ff <= cross_hit && cap_valid_ff && !cap_ready;
        end
    end
    assign cap_overrun = overrun_ff;

    rbuf_fifo2 #(
        .W(DATA_W)
    ) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(standby),
        .in_valid(cap_valid_ff),
        .in_ready(cap_ready),
        .in_data(cap_data_ff),
        .out_valid(buf_valid),
        .out_ready(q_ready),
        .out_data(buf_data)
    );

    assign buf_pop = buf_valid && q_ready;

    // q_ff changes only when a captured word is drained or standby clears it
    always_ff @(posedge clk) begin
        if (standby) begin
            q_ff <= Q_RESET;
        end else if (buf_pop) begin
            q_ff <= buf_data;
        end
    end

    always_ff @(posedge clk) begin
        if (standby) begin
            q_update_ff <= 1'b0;
        end else begin
            q_update_ff <= buf_pop;
        end
    end
    assign q_update = q_update_ff;

    // pin reset forces outputs low without waiting for a clock edge
    assign q = rst_pin_n ? q_ff : Q_RESET;
endmodule // rbuf_top
`default_nettype wire

// ==== core/rbuf_pkg.sv ====
/*
 * Shared constants for the 14-bit registered buffer: data width, pin
 * synchroniser depth, buffer depth and reset values.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package rbuf_pkg;
    localparam int DATA_W = 14;
    localparam int SYNC_STAGES = 3;
    localparam int FIFO_DEPTH = 2;
    localparam int FIFO_CNT_W = 2;
    localparam logic [DATA_W-1:0] Q_RESET = 14'h0000;
    localparam logic [FIFO_CNT_W-1:0] CNT_EMPTY = 2'h0;
    localparam logic [FIFO_CNT_W-1:0] CNT_FULL = 2'h2;
    // Position of the clock pair in the synchronised pin vector
    localparam int PIN_CK_T = DATA_W;
    localparam int PIN_CK_C = DATA_W + 1;
    localparam int PIN_W = DATA_W + 2;
    typedef logic [DATA_W-1:0] rbuf_word_t;
endpackage

// ==== core/rbuf_fifo2.sv ====
/*
 * Two-entry buffer with valid/ready on both sides, flip-flop storage.
 * Assumes one clock, synchronous active-high reset, and a synchronous
 * flush that empties it in one cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module rbuf_fifo2
    import rbuf_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic flush, // Empties the buffer
    input wire logic in_valid, // Word offered
    output logic in_ready, // Buffer has room
    input wire logic [W-1:0] in_data, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Drain side takes word
    output logic [W-1:0] out_data // Oldest word
);
    logic [W-1:0] mem_ff [FIFO_DEPTH];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [FIFO_CNT_W-1:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != CNT_FULL);
    assign out_valid = (cnt_ff != CNT_EMPTY);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= CNT_EMPTY;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end
endmodule // rbuf_fifo2
`default_nettype wire

// ==== tb/rbuf_top_monitor.sv ====
/* Port checker for rbuf_top.
   Bound to rbuf_top below; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module rbuf_chk
    import rbuf_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic rst_pin_n, // Pin reset
    input wire logic [rbuf_pkg::DATA_W-1:0] q, // Outputs
    input wire logic q_update, // New word
    input wire logic q_ready, // Ready
    input wire logic rcv_enable, // Receivers
    input wire logic cap_overrun // Lost word
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_pop; q_update |-> $past(q_ready); endproperty
    a_pop: assert property (p_pop) else $error("pop without ready");
    property p_keep; rst_pin_n && $past(rst_pin_n) && !q_update |-> $stable(q); endproperty
    a_keep: assert property (p_keep) else $error("q moved");
    property p_clr; !rst_pin_n |-> q == Q_RESET; endproperty
    a_clr: assert property (p_clr) else $error("q not low");
    property p_off; $fell(rst_pin_n) |-> ##[1:4] !rcv_enable; endproperty
    a_off: assert property (p_off) else $error("receivers on");
    property p_qt; !rcv_enable |-> q == Q_RESET && !q_update && !cap_overrun; endproperty
    a_qt: assert property (p_qt) else $error("busy in standby");
    c_b2b: cover property (q_update ##1 q_update);
    c_stall: cover property (!q_ready ##1 q_ready);
    c_off: cover property ($fell(rcv_enable));
    c_ovr: cover property (cap_overrun);
endmodule // rbuf_chk
bind rbuf_top rbuf_chk u_chk(.clk(clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .q(q), .q_update(q_update),
    .q_ready(q_ready), .rcv_enable(rcv_enable), .cap_overrun(cap_overrun));
`default_nettype wire

// ==== tb/rbuf_ctrl_model.sv ====
/* Controller model on the clock pair and data pins.
   Assumes tasks are called from the clock's rising edge. */
`timescale 1ns/10ps
`default_nettype none
module rbuf_ctrl_model
    import rbuf_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst_pin_n, // Pin reset
    output var logic ck_t_pin, // True clock
    output var logic ck_c_pin, // Complement
    output var logic [rbuf_pkg::DATA_W-1:0] d_pin // Data
);
    logic was_n = 1'b0;
    logic [1:0] gap = 2'h0;
    initial {ck_t_pin, ck_c_pin, d_pin} = 16'h4000;
    always @(posedge clk) begin
        was_n <= rst_pin_n;
        if (!rst_pin_n) begin
            gap <= gap + 2'h1;
            // Slow enough to pass the pin filter if the receivers stayed on
            if (gap == 2'h3) begin
                d_pin <= ~d_pin;
                ck_t_pin <= ~ck_t_pin;
                ck_c_pin <= ck_t_pin;
            end
        end else if (!was_n) begin
            gap <= 2'h0;
            ck_t_pin <= 1'b0;
            ck_c_pin <= 1'b1;
        end
    end
    task automatic send(input rbuf_word_t w);
        repeat (4) @(posedge clk);
        {ck_t_pin, ck_c_pin, d_pin} <= {2'h1, w};
        repeat (4) @(posedge clk);
        {ck_t_pin, ck_c_pin} <= 2'h2;
    endtask
    // Clocks both high: no crossing
    task automatic hold(input rbuf_word_t w);
        repeat (4) @(posedge clk);
        {ck_t_pin, ck_c_pin, d_pin} <= {2'h3, w};
    endtask
endmodule // rbuf_ctrl_model
`default_nettype wire

// ==== tb/testbench.sv ====
/* Bench for rbuf_top.
   Assumes the controller model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rbuf_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_pin_n = 1'b0;
    logic q_ready = 1'b1;
    logic ck_t;
    logic ck_c;
    logic upd;
    logic en;
    logic ovr;
    logic ovr_seen = 1'b0;
    rbuf_word_t d;
    rbuf_word_t q;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    rbuf_top dut(.clk(clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .ck_t_pin(ck_t), .ck_c_pin(ck_c), .d_pin(d),
        .q(q), .q_update(upd), .q_ready(q_ready), .rcv_enable(en), .cap_overrun(ovr));
    always @(posedge clk) begin
        if (ovr === 1'b1) begin
            ovr_seen <= 1'b1;
        end
    end
    rbuf_ctrl_model ctl(.clk(clk), .rst_pin_n(rst_pin_n), .ck_t_pin(ck_t), .ck_c_pin(ck_c), .d_pin(d));
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pop(input rbuf_word_t w);
        int n;
        n = 0;
        do begin
            step(1);
            n++;
        end while (upd !== 1'b1 && n < 40);
        chk(q === w, "word");
    endtask
    task automatic wake();
        int n;
        n = 0;
        while (en !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        step(4);
    endtask
    task automatic t_capture();
        rbuf_word_t w[3] = '{14'h3fff, 14'h0000, 14'h2a55};
        foreach (w[i]) begin
            ctl.send(w[i]);
            pop(w[i]);
        end
    endtask
    task automatic t_hold();
        ctl.hold(14'h1555);
        step(12);
        chk(q === 14'h2a55, "held");
    endtask
    task automatic t_stall();
        @(posedge clk);
        q_ready <= 1'b0;
        ctl.send(14'h0f0f);
        ctl.send(14'h3c3c);
        ctl.send(14'h0ff0);
        chk(ovr_seen === 1'b0, "early overrun");
        ctl.send(14'h3003);
        step(10);
        chk(q === 14'h2a55, "stalled");
        chk(ovr_seen === 1'b1, "no overrun");
        @(posedge clk);
        q_ready <= 1'b1;
        pop(14'h0f0f);
        pop(14'h3c3c);
        pop(14'h0ff0);
        step(12);
        chk(q === 14'h0ff0, "dropped word shown");
    endtask
    task automatic t_reset();
        @(posedge clk);
        rst_pin_n <= 1'b0;
        step(0);
        chk(q === Q_RESET, "not low");
        step(6);
        chk(en === 1'b0, "receivers on");
        @(posedge clk);
        rst_pin_n <= 1'b1;
        wake();
        step(8);
        chk(q === Q_RESET, "floating captured");
        ctl.send(14'h1234);
        pop(14'h1234);
        chk(ovr_seen === 1'b1, "overrun lost");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rst_pin_n <= 1'b1;
        wake();
        t_capture();
        t_hold();
        t_stall();
        t_reset();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
